// ### design/bir_top.sv
// Interrupter, acknowledge daisy-chain driver and handler request front end
// with an AXI4-Lite register slave standing as the local board slave.
// Assumes backplane pins arrive asynchronously; open-drain lines are
// resolved outside from the enables (enable high pulls the line low).
//
// Summary of operation
// - Handler serves configurable contiguous line range only
// - Interrupter drives one configured request line
// - Byte vector answers all widths, low byte
// - Halfword vector answers 16/32, low sixteen lines
// - Word vector answers only 32-bit cycles
// - Register release: hold until access, 2 us
// - Acknowledge release: hold until cycle, 500 ns
// - Release preferably within 50 ns
// - Always supply vector for own acknowledge
// - Register release triggered by register access
// - Acknowledge release triggered by vector read
// - Local slave signals register access completion
// - Chain driver in first slot watches acknowledge
// - Acknowledge then strobe low drives chain out
// - Idle interrupter forwards chain falling edge
// - Vector on data before acknowledge strobe; here vector and strobe go out in the same cycle
// - Answer only when all conditions, else pass
// - Line number binary on A3..A1
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bir_top
    import bir_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire bir_pins_in_t pins_in,
    output bir_pins_out_t pins_out,
    output logic reg_accessed,
    output logic handler_request,
    output logic [2:0] handler_line
);

    // Mask of lines lo..hi inclusive; empty when lo is above hi
    function automatic logic [6:0] line_range(input logic [2:0] lo, input logic [2:0] hi);
        logic [6:0] m;
        m = '0;
        for (int i = 1; i <= 7; i++) begin
            if (i >= int'(lo) && i <= int'(hi)) begin
                m[i-1] = 1'b1;
            end
        end
        return m;
    endfunction

    // Byte lanes driven for a vector capability
    function automatic logic [31:0] lane_mask(input bir_width_t w);
        case (w)
            BIR_W8: lane_mask = 32'h0000_00ff;
            BIR_W16: lane_mask = 32'h0000_ffff;
            BIR_W32: lane_mask = 32'hffff_ffff;
            default: lane_mask = 32'h0000_00ff;
        endcase
    endfunction

    logic [31:0] ctrl_q;
    logic [31:0] vec_q;
    logic pend_q;
    bir_pins_in_t sync1_q;
    bir_pins_in_t sync2_q;
    logic chain_lo_q;
    bir_state_t state_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic touched_q;
    logic hreq_q;
    logic [2:0] hline_q;
    bir_pins_out_t out_q;

    // Control fields
    logic [2:0] line_cfg;
    bir_width_t cap_cfg;
    logic mode_release_on_register_access;
    logic slot1_cfg;
    assign line_cfg = ctrl_q[BIR_CTRL_LINE +: 3];
    assign cap_cfg = bir_width_t'(ctrl_q[BIR_CTRL_CAP +: 2]);
    assign mode_release_on_register_access = ctrl_q[BIR_CTRL_MODE];
    assign slot1_cfg = ctrl_q[BIR_CTRL_SLOT1];

    // Two-stage synchroniser on every backplane input
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
        end
    end

    // Decoded bus levels from the second stage only
    logic ds0_lo;
    logic strobes_hi;
    logic chain_lo;
    logic chain_fall;
    bir_width_t req_width;
    logic answer_ok;
    assign ds0_lo = !sync2_q.ds0_n;
    assign strobes_hi = sync2_q.ds0_n && sync2_q.ds1_n;
    // First slot: acknowledge low then strobe low makes the chain edge
    assign chain_lo = slot1_cfg ? (!sync2_q.iack_n && ds0_lo)
                                : !sync2_q.iackin_n;
    assign chain_fall = chain_lo && !chain_lo_q;

    // Width the handler asks for, from long-word and both strobes
    always_comb begin
        if (!sync2_q.lword_n && !sync2_q.ds1_n && ds0_lo) begin
            req_width = BIR_W32;
        end else if (!sync2_q.ds1_n && ds0_lo) begin
            req_width = BIR_W16;
        end else begin
            req_width = BIR_W8;
        end
    end

    // All four answer conditions; width must cover our own
    assign answer_ok = pend_q && (sync2_q.addr == line_cfg)
                       && (req_width >= cap_cfg) && (line_cfg != 3'd0);

    // Edge memory for the daisy-chain input
    always_ff @(posedge clock) begin
        if (reset) begin
            chain_lo_q <= 1'b0;
        end else begin
            chain_lo_q <= chain_lo;
        end
    end

    // Release events
    logic rel_ack;
    logic rel_reg;
    assign rel_ack = (state_q == BIR_ST_DTACK) && strobes_hi && !mode_release_on_register_access;
    assign rel_reg = touched_q && mode_release_on_register_access;

    // Acknowledge sequencer
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= BIR_ST_IDLE;
        end else begin
            case (state_q)
                BIR_ST_IDLE: begin
                    if (chain_fall) begin
                        state_q <= BIR_ST_WAIT_DS;
                    end
                end
                BIR_ST_WAIT_DS: begin
                    // Width is known only once the strobes are low
                    if (!chain_lo) begin
                        state_q <= BIR_ST_IDLE;
                    end else if (ds0_lo) begin
                        state_q <= answer_ok ? BIR_ST_DRIVE : BIR_ST_PASS;
                    end
                end
                BIR_ST_DRIVE: begin
                    state_q <= BIR_ST_DTACK;
                end
                BIR_ST_DTACK: begin
                    if (strobes_hi) begin
                        state_q <= BIR_ST_IDLE;
                    end
                end
                BIR_ST_PASS: begin
                    if (!chain_lo) begin
                        state_q <= BIR_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= BIR_ST_IDLE;
                end
            endcase
        end
    end

    // Pending request: software set wins over a release in the same cycle
    logic set_req;
    always_ff @(posedge clock) begin
        if (reset) begin
            pend_q <= 1'b0;
        end else if (set_req) begin
            pend_q <= 1'b1;
        end else if (rel_ack || rel_reg) begin
            pend_q <= 1'b0;
        end
    end

    // Registered pin drive; release lands one cycle after its trigger
    always_ff @(posedge clock) begin
        if (reset) begin
            out_q <= '{irq_oe: '0, iackout_n: 1'b1, dtack_oe: 1'b0, data: '0, data_oe: '0};
        end else begin
            for (int i = 0; i < 7; i++) begin
                out_q.irq_oe[i] <= pend_q && !(rel_ack || rel_reg)
                                   && (line_cfg == 3'(i + 1));
            end
            out_q.iackout_n <= !(state_q == BIR_ST_PASS && chain_lo);
            // Vector lanes go out in the same cycle as the acknowledge strobe
            if (state_q == BIR_ST_DRIVE || state_q == BIR_ST_DTACK) begin
                out_q.data <= vec_q & lane_mask(cap_cfg);
                out_q.data_oe <= lane_mask(cap_cfg);
            end else begin
                out_q.data <= '0;
                out_q.data_oe <= '0;
            end
            out_q.dtack_oe <= (state_q == BIR_ST_DRIVE)
                              || (state_q == BIR_ST_DTACK && !strobes_hi);
        end
    end
    assign pins_out = out_q;

    // Handler front end: highest active served line, coded in binary
    logic [6:0] served_act;
    logic [2:0] best_line;
    assign served_act = ~sync2_q.irq_n & line_range(ctrl_q[BIR_CTRL_HLO +: 3],
                                                    ctrl_q[BIR_CTRL_HHI +: 3]);
    always_comb begin
        best_line = 3'd0;
        for (int i = 0; i < 7; i++) begin
            if (served_act[i]) begin
                best_line = 3'(i + 1);
            end
        end
    end

    // A register-release requester may still hold the line briefly after
    // the access; the far handler masks it, so no guard is kept here.
    always_ff @(posedge clock) begin
        if (reset) begin
            hreq_q <= 1'b0;
            hline_q <= 3'd0;
        end else begin
            hreq_q <= (best_line != 3'd0);
            hline_q <= best_line;
        end
    end
    assign handler_request = hreq_q;
    assign handler_line = hline_q;

    // AXI write address and data are latched independently
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic wr_ctrl;
    logic wr_vec;
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_hold_q && w_hold_q;
    assign wr_ctrl = do_write && (awaddr_q == AW'(BIR_CTRL_OFS));
    assign wr_vec = do_write && (awaddr_q == AW'(BIR_VEC_OFS));
    assign set_req = wr_ctrl && wstrb_q[0] && wdata_q[BIR_CTRL_REQ];

    always_ff @(posedge clock) begin
        if (reset) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (aw_hs) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end
            if (w_hs) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Register storage with byte enables; the request bit is not stored
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= BIR_CTRL_RST;
            vec_q <= BIR_VEC_RST;
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (wr_ctrl && wstrb_q[b]) begin
                    ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                end
                if (wr_vec && wstrb_q[b]) begin
                    vec_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                end
            end
            ctrl_q[31:BIR_CTRL_BITS] <= '0;
            ctrl_q[BIR_CTRL_REQ] <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clock) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= BIR_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_ctrl || wr_vec) ? BIR_RESP_OKAY : BIR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Read channel: one beat, answered the cycle after the address
    logic ar_hs;
    logic rd_stat;
    assign s_axi_arready = !rvalid_q;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_stat = ar_hs && (s_axi_araddr == AW'(BIR_STAT_OFS));

    always_ff @(posedge clock) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= BIR_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rresp_q <= BIR_RESP_OKAY;
            if (s_axi_araddr == AW'(BIR_CTRL_OFS)) begin
                rdata_q <= ctrl_q;
            end else if (s_axi_araddr == AW'(BIR_VEC_OFS)) begin
                rdata_q <= vec_q;
            end else if (rd_stat) begin
                rdata_q <= '0;
                rdata_q[BIR_STAT_PEND] <= pend_q;
                rdata_q[BIR_STAT_DRIVE] <= |out_q.irq_oe;
                rdata_q[BIR_STAT_STATE +: 3] <= state_q;
                rdata_q[BIR_STAT_HLINE +: 3] <= hline_q;
                rdata_q[BIR_STAT_HREQ] <= hreq_q;
            end else begin
                rdata_q <= '0;
                rresp_q <= BIR_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Completion of a status read or a control write that does not set a
    // request; a set in the same write must not release itself.
    always_ff @(posedge clock) begin
        if (reset) begin
            touched_q <= 1'b0;
        end else begin
            touched_q <= rd_stat || (wr_ctrl && !set_req);
        end
    end
    assign reg_accessed = touched_q;

endmodule

// ### include/bir_pkg.sv
// Package for the bus interrupt request/release block: register map,
// field positions, reset values, width codes, states, timing and pin bundles.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register slave.
package bir_pkg;

    // Register byte offsets
    localparam logic [7:0] BIR_CTRL_OFS = 8'h00;
    localparam logic [7:0] BIR_VEC_OFS = 8'h04;
    localparam logic [7:0] BIR_STAT_OFS = 8'h08;

    // Control register fields
    localparam int BIR_CTRL_REQ = 0;
    localparam int BIR_CTRL_LINE = 1;
    localparam int BIR_CTRL_CAP = 4;
    localparam int BIR_CTRL_MODE = 6;
    localparam int BIR_CTRL_SLOT1 = 7;
    localparam int BIR_CTRL_HLO = 8;
    localparam int BIR_CTRL_HHI = 11;
    localparam int BIR_CTRL_BITS = 14;

    // Status register fields
    localparam int BIR_STAT_PEND = 0;
    localparam int BIR_STAT_DRIVE = 1;
    localparam int BIR_STAT_STATE = 2;
    localparam int BIR_STAT_HLINE = 5;
    localparam int BIR_STAT_HREQ = 8;

    // Reset values: line 1, byte vector, release on acknowledge, handler 1..7
    localparam logic [31:0] BIR_CTRL_RST = 32'h0000_3902;
    localparam logic [31:0] BIR_VEC_RST = 32'h0000_00ff;

    // AXI responses
    localparam logic [1:0] BIR_RESP_OKAY = 2'b00;
    localparam logic [1:0] BIR_RESP_SLVERR = 2'b10;

    // Release deadlines after the last strobe rises, as longest counts
    localparam int BIR_CLK_NS = 20;
    localparam int BIR_REL_RELEASE_ON_REGISTER_ACCESS_NS = 2000;
    localparam int BIR_REL_RELEASE_ON_ACKNOWLEDGE_NS = 500;
    localparam int BIR_REL_FAST_NS = 50;
    localparam int BIR_REL_RELEASE_ON_REGISTER_ACCESS_CYC = BIR_REL_RELEASE_ON_REGISTER_ACCESS_NS / BIR_CLK_NS;
    localparam int BIR_REL_RELEASE_ON_ACKNOWLEDGE_CYC = BIR_REL_RELEASE_ON_ACKNOWLEDGE_NS / BIR_CLK_NS;
    localparam int BIR_REL_FAST_CYC = BIR_REL_FAST_NS / BIR_CLK_NS;

    // Acknowledge vector width, also the width of a requested cycle
    typedef enum logic [1:0] {
        BIR_W8 = 2'b00,
        BIR_W16 = 2'b01,
        BIR_W32 = 2'b10
    } bir_width_t;

    // Interrupter acknowledge sequencer
    typedef enum logic [2:0] {
        BIR_ST_IDLE = 3'b000,
        BIR_ST_WAIT_DS = 3'b001,
        BIR_ST_DRIVE = 3'b010,
        BIR_ST_DTACK = 3'b011,
        BIR_ST_PASS = 3'b100
    } bir_state_t;

    // Backplane inputs, all active low except the address code
    typedef struct packed {
        logic iack_n;
        logic iackin_n;
        logic ds0_n;
        logic ds1_n;
        logic lword_n;
        logic [2:0] addr;
        logic [6:0] irq_n;
    } bir_pins_in_t;

    // Backplane outputs; each enable high while the line is driven low or data
    typedef struct packed {
        logic [6:0] irq_oe;
        logic iackout_n;
        logic dtack_oe;
        logic [31:0] data;
        logic [31:0] data_oe;
    } bir_pins_out_t;

endpackage

// ### testbench/bir_top_asserts.sv
// Checker for bir_top: acknowledge, chain, release and handler pin properties.
// Assumes it is bound into bir_top and sees that module's ports only.
`timescale 1ns/1ps
module bir_top_asserts
    import bir_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire bir_pins_in_t pins_in,
    input wire bir_pins_out_t pins_out,
    input wire logic reg_accessed,
    input wire logic handler_request
);
    logic [31:0] oe;
    logic ack_n;
    // Short aliases keep the properties readable
    assign oe = pins_out.data_oe;
    assign ack_n = pins_out.iackout_n;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    one_line_a: assert property ($onehot0(pins_out.irq_oe))
        else $error("several request lines driven");
    lane_set_a: assert property (
        oe inside {32'h0, 32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff})
        else $error("vector lanes not a legal width");
    vec_first_a: assert property ($rose(pins_out.dtack_oe) |-> oe != 32'h0)
        else $error("acknowledge strobe without vector");
    ans_pending_a: assert property ($rose(pins_out.dtack_oe) |-> pins_out.irq_oe != 7'h0)
        else $error("answer without a pending request");
    pass_quiet_a: assert property (!ack_n |-> !pins_out.dtack_oe && oe == 32'h0)
        else $error("passed edge while answering");
    pass_cause_a: assert property (
        $fell(ack_n) |-> $past(!pins_in.iackin_n || !pins_in.iack_n, 2))
        else $error("chain output fell without a chain input");
    pass_end_a: assert property (
        (pins_in.iackin_n && pins_in.iack_n) [*4] |=> ack_n)
        else $error("chain output held after chain input rose");
    dtack_end_a: assert property ((pins_in.ds0_n && pins_in.ds1_n) [*4] |=>
        !pins_out.dtack_oe)
        else $error("acknowledge strobe held after strobes rose");
    data_end_a: assert property ($fell(pins_out.dtack_oe) |=> oe == 32'h0)
        else $error("vector held after acknowledge strobe");
    reg_pulse_a: assert property (reg_accessed |=> !reg_accessed)
        else $error("access signal longer than one cycle");
    hreq_cause_a: assert property (
        $rose(handler_request) |-> $past(pins_in.irq_n, 2) != 7'h7f)
        else $error("handler request without a low line");

    // Main scenarios seen at least once
    answer_c: cover property ($rose(pins_out.dtack_oe));
    pass_c: cover property ($fell(ack_n));
    access_c: cover property (reg_accessed);
endmodule

bind bir_top bir_top_asserts i_chk (.clock(clock), .reset(reset), .pins_in(pins_in),
    .pins_out(pins_out), .reg_accessed(reg_accessed), .handler_request(handler_request));

// ### testbench/bir_handler_model.sv
// Far side model: an acknowledging handler plus the rest of the backplane.
// Assumes pull-ups on data and request lines; the bench calls ack().
`timescale 1ns/1ps
module bir_handler_model
    import bir_pkg::*;
(
    input wire logic clock,
    input wire bir_pins_out_t pins_out,
    input wire logic [6:0] ext_irq,
    output bir_pins_in_t pins_in
);
    logic iack_n = 1'h1, iackin_n = 1'h1, ds0_n = 1'h1, ds1_n = 1'h1, lword_n = 1'h1;
    logic [2:0] addr = 3'h7;
    logic [31:0] bus;
    // Terminators pull undriven data lines high; request lines go low while any board drives them
    assign bus = (pins_out.data & pins_out.data_oe) | ~pins_out.data_oe;
    assign pins_in = {iack_n, iackin_n, ds0_n, ds1_n, lword_n, addr,
        ~(pins_out.irq_oe | ext_irq)};

    // One acknowledge cycle; early flags a pass seen before the strobe fell
    task automatic ack(input logic [2:0] ln, input bir_width_t w, output logic [31:0] v,
        output logic ok, output logic ps, output logic early);
        int n;
        ok = 1'h0;
        ps = 1'h0;
        early = 1'h0;
        v = 32'h0;
        @(posedge clock);
        addr <= ln;
        iack_n <= 1'h0;
        iackin_n <= 1'h0;
        repeat (6) begin
            @(posedge clock);
            early |= !pins_out.iackout_n;
        end
        ds0_n <= 1'h0;
        ds1_n <= (w == BIR_W8);
        lword_n <= (w != BIR_W32);
        for (n = 0; n < 40 && !ok && !ps; n++) begin
            @(posedge clock);
            ok = pins_out.dtack_oe;
            ps = !pins_out.iackout_n;
            v = bus;
        end
        ds0_n <= 1'h1;
        ds1_n <= 1'h1;
        lword_n <= 1'h1;
        for (n = 0; n < 40 && pins_out.dtack_oe; n++) @(posedge clock);
        iack_n <= 1'h1;
        iackin_n <= 1'h1;
        addr <= 3'h7;
    endtask
endmodule

// ### testbench/bir_top_tb.sv
// Bench for bir_top: registers, vector widths, both release kinds, chain, handler.
// Assumes the handler model stands for every other board on the backplane.
`timescale 1ns/1ps
`define CK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end
module bir_top_tb
    import bir_pkg::*;
;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, reg_accessed, handler_request;
    logic [1:0] bresp, rresp;
    logic [2:0] handler_line;
    logic [6:0] ext_irq = 7'h0;
    bir_pins_in_t pins_in;
    bir_pins_out_t pins_out;
    int errors = 0, comparisons = 0, pulses = 0;

    bir_top i_dut (.clock(clock), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_in(pins_in),
        .pins_out(pins_out), .reg_accessed(reg_accessed),
        .handler_request(handler_request), .handler_line(handler_line));
    bir_handler_model i_hm (.clock(clock), .pins_out(pins_out), .ext_irq(ext_irq),
        .pins_in(pins_in));

    // Clock and a count of access pulses
    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (reg_accessed) pulses <= pulses + 1;
    end

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tmo;
        errors++;
        $display("BAD bus wait exp answer got none");
        report_and_stop;
    endtask

    // Register write; both channels offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'h0;
        if (n == 50) tmo;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n == 50) tmo;
    endtask

    // Cycles until no request line is driven; 200 means never
    task automatic quiet(output int n);
        for (n = 0; n < 200 && pins_out.irq_oe != 7'h0; n++) @(posedge clock);
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] ln, input logic [1:0] cap,
        input logic mode, input logic s1, input logic req);
        ctl = BIR_CTRL_RST;
        ctl[BIR_CTRL_REQ] = req;
        ctl[BIR_CTRL_LINE +: 3] = ln;
        ctl[BIR_CTRL_CAP +: 2] = cap;
        ctl[BIR_CTRL_MODE] = mode;
        ctl[BIR_CTRL_SLOT1] = s1;
    endfunction

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axr(BIR_CTRL_OFS, d, r);
        `CK("ctrl reset", BIR_CTRL_RST, d)
        axr(BIR_VEC_OFS, d, r);
        `CK("vector reset", BIR_VEC_RST, d)
        axr(8'h10, d, r);
        `CK("unmapped read", BIR_RESP_SLVERR, r)
        axw(8'h0c, 32'h1234_5678, r);
        `CK("unmapped write", BIR_RESP_SLVERR, r)
    endtask

    // Every capability against every cycle width, wrong line first where width equals capability
    task automatic t_widths;
        logic [31:0] v, lane;
        logic [1:0] r;
        logic ok, ps, e;
        int n;
        axw(BIR_VEC_OFS, 32'ha5c3_9617, r);
        for (int c = 0; c < 3; c++) begin
            for (int w = 0; w < 3; w++) begin
                axw(BIR_CTRL_OFS, ctl(3'h4, c[1:0], 1'h0, 1'h0, 1'h1), r);
                repeat (2) @(posedge clock);
                `CK("request line", 7'h08, pins_out.irq_oe)
                if (w == c) begin
                    i_hm.ack(3'h3, BIR_W32, v, ok, ps, e);
                    `CK("wrong line pass", 1'h1, ps && !ok)
                end
                i_hm.ack(3'h4, bir_width_t'(w), v, ok, ps, e);
                `CK("answered", w >= c, ok)
                lane = (c == 0) ? 32'h0000_00ff : (c == 1) ? 32'h0000_ffff : 32'hffff_ffff;
                if (ok) `CK("vector", 32'ha5c3_9617 | ~lane, v)
                if (!ok) begin
                    `CK("held", 7'h08, pins_out.irq_oe)
                    i_hm.ack(3'h4, BIR_W32, v, ok, ps, e);
                end
                quiet(n);
                `CK("ack release", 1'h1, n <= BIR_REL_RELEASE_ON_ACKNOWLEDGE_CYC)
            end
        end
    endtask

    // Idle interrupter, normal and first-slot mode
    task automatic t_pass;
        logic [31:0] v;
        logic [1:0] r;
        logic ok, ps, e;
        for (int s = 0; s < 2; s++) begin
            axw(BIR_CTRL_OFS, ctl(3'h4, 2'h0, 1'h0, s[0], 1'h0), r);
            i_hm.ack(3'h4, BIR_W8, v, ok, ps, e);
            `CK("idle pass", 2'h1, {ok, ps})
            `CK("pass before strobe", 1'h0, e)
        end
    endtask

    task automatic t_release_on_register_access;
        logic [31:0] v;
        logic [1:0] r;
        logic ok, ps, e;
        int n, p;
        axw(BIR_CTRL_OFS, ctl(3'h6, 2'h0, 1'h1, 1'h0, 1'h1), r);
        i_hm.ack(3'h6, BIR_W16, v, ok, ps, e);
        `CK("register mode answer", 1'h1, ok)
        repeat (30) @(posedge clock);
        `CK("register mode hold", 7'h20, pins_out.irq_oe)
        p = pulses;
        axr(BIR_STAT_OFS, v, r);
        quiet(n);
        // Pending, driving, idle sequencer, own line 6 seen by handler 1..7
        `CK("status word", 32'h0000_01c3, v)
        `CK("status resp", BIR_RESP_OKAY, r)
        `CK("access pulse", p + 1, pulses)
        `CK("register release", 1'h1, n <= BIR_REL_RELEASE_ON_REGISTER_ACCESS_CYC)
    endtask

    // Served range 2..5, other boards drive the lines
    task automatic t_handler;
        logic [6:0] pat [5] = '{7'h40, 7'h15, 7'h01, 7'h02, 7'h30};
        logic [2:0] ex [5] = '{3'h0, 3'h5, 3'h0, 3'h2, 3'h5};
        logic [31:0] c;
        logic [1:0] r;
        int n;
        c = ctl(3'h0, 2'h0, 1'h0, 1'h0, 1'h0);
        c[BIR_CTRL_HLO +: 3] = 3'h2;
        c[BIR_CTRL_HHI +: 3] = 3'h5;
        axw(BIR_CTRL_OFS, c, r);
        for (int i = 0; i < 5; i++) begin
            ext_irq <= pat[i];
            for (n = 0; n < 12 && handler_line !== ex[i]; n++) @(posedge clock);
            repeat (3) @(posedge clock);
            `CK("handler line", ex[i], handler_line)
            `CK("handler request", ex[i] != 3'h0, handler_request)
        end
        ext_irq <= 7'h0;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'h0;
        t_regs;
        t_widths;
        t_pass;
        t_release_on_register_access;
        t_handler;
        report_and_stop;
    end
endmodule
